// [pkg/can_filter_pkg.sv]
// ****************************************************************
// Constants and carriers
// ****************************************************************
package can_filter_pkg;

   localparam int unsigned NUM_FILTERS = 4;
   localparam int unsigned NUM_MASKS = 4;
   localparam int unsigned NUM_FIFOS = 32;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned LEVEL_W = 6;
   localparam int unsigned FIRST_FILTER = 24;

   // Byte addresses
   localparam logic [9:0] ADDR_FILTER_CONTROL_SIX = 10'h000;
   localparam logic [9:0] ADDR_FIFO_DIRECTION = 10'h004;
   localparam logic [9:0] ADDR_IRQ_STATUS = 10'h008;
   localparam logic [9:0] ADDR_IRQ_CLEAR = 10'h00C;
   localparam logic [9:0] ADDR_IRQ_ENABLE = 10'h010;
   localparam logic [9:0] ADDR_FIFO_EVENT_BASE = 10'h100;
   localparam logic [2:0] FIFO_EVENT_PAGE = 3'h2;

   // Filter byte layout
   localparam int unsigned FILT_ENABLE_BIT = 7;
   localparam int unsigned FILT_MSEL_LSB = 5;
   localparam int unsigned FILT_FSEL_LSB = 0;

   // FIFO event register layout
   localparam int unsigned EVT_TX_HALF_BIT = 9;
   localparam int unsigned EVT_TX_EMPTY_BIT = 8;
   localparam int unsigned EVT_RX_OVFL_BIT = 3;
   localparam int unsigned EVT_RX_FULL_BIT = 2;
   localparam int unsigned EVT_RX_HALF_BIT = 1;
   localparam int unsigned EVT_RX_NEMPTY_BIT = 0;

   // Occupancy thresholds
   localparam logic [5:0] LEVEL_HALF = 6'h10;
   localparam logic [5:0] LEVEL_FULL = 6'h20;
   localparam logic [5:0] LEVEL_EMPTY = 6'h00;

   // Values after reset
   localparam logic [31:0] FILTER_CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] FIFO_DIRECTION_RESET = 32'h0000_0000;
   localparam logic [31:0] IRQ_ENABLE_RESET = 32'h0000_0000;
   localparam logic [31:0] IRQ_STATUS_RESET = 32'h0000_0000;

   typedef struct packed {
      logic enable;
      logic [1:0] mask_select;
      logic [4:0] fifo_select;
   } filter_cfg_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [9:0] adr;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic valid;
      logic [NUM_FILTERS-1:0][NUM_MASKS-1:0] hit;
   } cand_t;

   typedef struct packed {
      logic valid;
      logic [1:0] filter;
      logic [4:0] fifo;
   } accept_t;

   typedef struct packed {
      logic [LEVEL_W-1:0] level;
      logic overflow_event;
   } fifo_in_t;

endpackage

// [hdl/can_fifo_flags.sv]
`timescale 1ns/1ns
// ****************************************************************
// Status flags of one FIFO
// ****************************************************************
module can_fifo_flags (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // FIFO state
   input wire logic fifo_direction_tx_i,
   input wire logic [can_filter_pkg::LEVEL_W-1:0] level_i,
   input wire logic overflow_event_i,
   // Software clear of the overflow flag
   input wire logic overflow_clear_i,
   // Event register image
   output logic [31:0] event_word_o
);
   import can_filter_pkg::*;

   logic ovfl_q;
   logic ovfl_d;
   logic rx;

   assign rx = ~fifo_direction_tx_i;

   // Sticky overflow, set beats clear
   always_comb
   begin
      ovfl_d = ovfl_q;
      if (overflow_clear_i)
      begin
         ovfl_d = 1'b0;
      end
      if (fifo_direction_tx_i)
      begin
         ovfl_d = 1'b0;
      end
      else if (overflow_event_i)
      begin
         ovfl_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ovfl_q <= 1'b0;
      end
      else
      begin
         ovfl_q <= ovfl_d;
      end
   end

   // Live flags from occupancy, overflow flag from the sticky ovfl_q
   always_comb
   begin
      event_word_o = 32'h0000_0000;
      event_word_o[EVT_TX_HALF_BIT] = fifo_direction_tx_i && (level_i <= LEVEL_HALF);
      event_word_o[EVT_TX_EMPTY_BIT] = fifo_direction_tx_i && (level_i == LEVEL_EMPTY);
      event_word_o[EVT_RX_OVFL_BIT] = rx && ovfl_q;
      event_word_o[EVT_RX_FULL_BIT] = rx && (level_i == LEVEL_FULL);
      event_word_o[EVT_RX_HALF_BIT] = rx && (level_i >= LEVEL_HALF);
      event_word_o[EVT_RX_NEMPTY_BIT] = rx && (level_i != LEVEL_EMPTY);
   end

   property p_tx_half;
      @(posedge clk_i) disable iff (rst_i)
      fifo_direction_tx_i |-> event_word_o[EVT_TX_HALF_BIT] == (level_i <= 6'h10);
   endproperty
   a_tx_half: assert property (p_tx_half) else $error("tx half-empty flag wrong");

   property p_tx_empty;
      @(posedge clk_i) disable iff (rst_i)
      fifo_direction_tx_i && level_i == 6'h00 |-> event_word_o[EVT_TX_EMPTY_BIT];
   endproperty
   a_tx_empty: assert property (p_tx_empty) else $error("tx empty flag not set");

   property p_ovfl_set;
      @(posedge clk_i) disable iff (rst_i)
      rx && overflow_event_i ##1 rx |-> event_word_o[EVT_RX_OVFL_BIT];
   endproperty
   a_ovfl_set: assert property (p_ovfl_set) else $error("overflow flag not set");

   property p_rx_full;
      @(posedge clk_i) disable iff (rst_i)
      rx |-> event_word_o[EVT_RX_FULL_BIT] == (level_i == 6'h20);
   endproperty
   a_rx_full: assert property (p_rx_full) else $error("rx full flag wrong");

   property p_rx_half;
      @(posedge clk_i) disable iff (rst_i)
      rx |-> event_word_o[EVT_RX_HALF_BIT] == (level_i >= 6'h10);
   endproperty
   a_rx_half: assert property (p_rx_half) else $error("rx half-full flag wrong");

   property p_rx_nempty;
      @(posedge clk_i) disable iff (rst_i)
      rx && level_i == 6'h01 |-> event_word_o[EVT_RX_NEMPTY_BIT];
   endproperty
   a_rx_nempty: assert property (p_rx_nempty) else $error("rx not-empty flag wrong");

   property p_dir_zero;
      @(posedge clk_i) disable iff (rst_i)
      fifo_direction_tx_i |-> event_word_o[3:0] == 4'h0;
   endproperty
   a_dir_zero: assert property (p_dir_zero) else $error("rx flags set on tx fifo");

   property p_live;
      @(posedge clk_i) disable iff (rst_i)
      $stable(level_i) && $stable(fifo_direction_tx_i) |-> $stable(event_word_o[9:8]);
   endproperty
   a_live: assert property (p_live) else $error("flag moved without occupancy change");

   property p_ovfl_hold;
      @(posedge clk_i) disable iff (rst_i)
      ovfl_q && !overflow_clear_i && rx ##1 rx |-> ovfl_q;
   endproperty
   a_ovfl_hold: assert property (p_ovfl_hold) else $error("overflow flag lost");

   property p_reserved;
      @(posedge clk_i) disable iff (rst_i)
      event_word_o[7:4] == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved event bits set");

endmodule

// [hdl/can_filter_fifo_status.sv]
`timescale 1ns/1ns
module can_filter_fifo_status (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire can_filter_pkg::wb_req_t wb_req_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Acceptance candidates and result
   input wire can_filter_pkg::cand_t cand_i,
   output can_filter_pkg::accept_t accept_o,
   // Filter settings for the bit engine
   output can_filter_pkg::filter_cfg_t [can_filter_pkg::NUM_FILTERS-1:0] filter_cfg_o,
   // FIFO occupancy and events
   input wire can_filter_pkg::fifo_in_t [can_filter_pkg::NUM_FIFOS-1:0] fifo_i,
   output logic [31:0] fifo_direction_tx_o,
   // Interrupt
   output logic irq_o
);
   import can_filter_pkg::*;

   // ****************************************************************
   // Decode helpers
   // ****************************************************************
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   function automatic filter_cfg_t filter_update(input filter_cfg_t old_v,
                                                 input logic [7:0] new_v);
      filter_cfg_t res;
      res = old_v;
      res.enable = new_v[FILT_ENABLE_BIT];
      if (!old_v.enable)
      begin
         res.mask_select = new_v[FILT_MSEL_LSB +: 2];
         res.fifo_select = new_v[FILT_FSEL_LSB +: 5];
      end
      return res;
   endfunction

   function automatic logic is_event_addr(input logic [9:0] adr);
      return adr[9:7] == FIFO_EVENT_PAGE;
   endfunction

   // ****************************************************************
   // Bus handshake
   // ****************************************************************
   logic ack_q;
   logic req;
   logic wr_en;
   logic rd_take;
   logic [9:0] adr_w;
   logic [4:0] evt_idx;
   logic [31:0] wdat;
   logic [3:0] sel;

   assign req = wb_req_i.cyc & wb_req_i.stb;
   assign adr_w = {wb_req_i.adr[9:2], 2'b00};
   assign evt_idx = wb_req_i.adr[6:2];
   assign wdat = wb_req_i.dat;
   assign sel = wb_req_i.sel;
   // Write lands on the edge at which the master sees ack
   assign wr_en = req & wb_req_i.we & ack_q;
   assign rd_take = req & ~ack_q;
   assign wb_ack_o = ack_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= req & ~ack_q;
      end
   end

   // ****************************************************************
   // Filter control
   // ****************************************************************
   filter_cfg_t [NUM_FILTERS-1:0] filter_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         filter_q <= FILTER_CONTROL_RESET;
      end
      else if (wr_en && adr_w == ADDR_FILTER_CONTROL_SIX)
      begin
         for (int f = 0; f < NUM_FILTERS; f++)
         begin
            if (sel[f])
            begin
               filter_q[f] <= filter_update(filter_q[f], wdat[8*f +: 8]);
            end
         end
      end
   end

   assign filter_cfg_o = filter_q;

   // ****************************************************************
   // FIFO direction and interrupt registers
   // ****************************************************************
   logic [31:0] dir_q;
   logic [31:0] irq_en_q;
   logic [31:0] irq_status_q;
   logic [31:0] irq_set;
   logic [31:0] irq_clr;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dir_q <= FIFO_DIRECTION_RESET;
      end
      else if (wr_en && adr_w == ADDR_FIFO_DIRECTION)
      begin
         dir_q <= merge_sel(dir_q, wdat, sel);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_en_q <= IRQ_ENABLE_RESET;
      end
      else if (wr_en && adr_w == ADDR_IRQ_ENABLE)
      begin
         irq_en_q <= merge_sel(irq_en_q, wdat, sel);
      end
   end

   always_comb
   begin
      irq_clr = 32'h0000_0000;
      if (wr_en && adr_w == ADDR_IRQ_CLEAR)
      begin
         irq_clr = merge_sel(32'h0000_0000, wdat, sel);
      end
   end

   // Set beats clear in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_status_q <= IRQ_STATUS_RESET;
      end
      else
      begin
         irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
      end
   end

   assign irq_o = |(irq_status_q & irq_en_q);
   assign fifo_direction_tx_o = dir_q;

   // ****************************************************************
   // Per-FIFO flags
   // ****************************************************************
   logic [NUM_FIFOS-1:0][31:0] event_word;
   logic [NUM_FIFOS-1:0] ovfl_clear;

   generate
      for (genvar n = 0; n < NUM_FIFOS; n++)
      begin : g_fifo
         assign ovfl_clear[n] = wr_en && is_event_addr(wb_req_i.adr) && evt_idx == n
                                && sel[0] && wdat[EVT_RX_OVFL_BIT];
         assign irq_set[n] = fifo_i[n].overflow_event & ~dir_q[n];

         can_fifo_flags u_flags (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .fifo_direction_tx_i(dir_q[n]),
            .level_i(fifo_i[n].level),
            .overflow_event_i(fifo_i[n].overflow_event),
            .overflow_clear_i(ovfl_clear[n]),
            .event_word_o(event_word[n])
         );
      end
   endgenerate

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [31:0] rdata_d;
   logic [31:0] dat_q;

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (is_event_addr(wb_req_i.adr))
      begin
         rdata_d = event_word[evt_idx];
      end
      else
      begin
         unique case (adr_w)
            ADDR_FILTER_CONTROL_SIX: rdata_d = filter_q;
            ADDR_FIFO_DIRECTION: rdata_d = dir_q;
            ADDR_IRQ_STATUS: rdata_d = irq_status_q;
            ADDR_IRQ_ENABLE: rdata_d = irq_en_q;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dat_q <= 32'h0000_0000;
      end
      else if (rd_take)
      begin
         dat_q <= wb_req_i.we ? 32'h0000_0000 : rdata_d;
      end
   end

   assign wb_dat_o = dat_q;

   // ****************************************************************
   // Acceptance routing
   // ****************************************************************
   accept_t accept_q;
   accept_t accept_d;
   logic [NUM_FILTERS-1:0] sel_hit;

   always_comb
   begin
      for (int f = 0; f < NUM_FILTERS; f++)
      begin
         sel_hit[f] = filter_q[f].enable
                      && cand_i.hit[f][filter_q[f].mask_select];
      end
   end

   // Lowest numbered filter wins
   always_comb
   begin
      accept_d = '0;
      for (int f = NUM_FILTERS - 1; f >= 0; f--)
      begin
         if (cand_i.valid && sel_hit[f])
         begin
            accept_d.valid = 1'b1;
            accept_d.filter = 2'(f);
            accept_d.fifo = filter_q[f].fifo_select;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         accept_q <= '0;
      end
      else
      begin
         accept_q <= accept_d;
      end
   end

   assign accept_o = accept_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic [NUM_FILTERS-1:0] en_vec;
   logic [4:0] fsel0;
   logic [1:0] msel0;

   always_comb
   begin
      for (int f = 0; f < NUM_FILTERS; f++)
      begin
         en_vec[f] = filter_q[f].enable;
      end
   end

   assign fsel0 = filter_q[0].fifo_select;
   assign msel0 = filter_q[0].mask_select;

   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      req && !ack_q |=> ack_q ##1 !ack_q;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");

   property p_disabled;
      @(posedge clk_i) disable iff (rst_i)
      cand_i.valid && en_vec == 4'h0 |=> !accept_o.valid;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled filter accepted");

   property p_mask;
      @(posedge clk_i) disable iff (rst_i)
      cand_i.valid && en_vec[0] && cand_i.hit[0] == (4'h1 << msel0)
      |=> accept_o.valid && accept_o.filter == 2'h0;
   endproperty
   a_mask: assert property (p_mask) else $error("selected mask hit not accepted");

   property p_mask_other;
      @(posedge clk_i) disable iff (rst_i)
      cand_i.valid && en_vec == 4'h1 && cand_i.hit[0] == ~(4'h1 << msel0)
      |=> !accept_o.valid;
   endproperty
   a_mask_other: assert property (p_mask_other) else $error("wrong mask used");

   property p_fifo;
      @(posedge clk_i) disable iff (rst_i)
      cand_i.valid && sel_hit[0] |=> accept_o.fifo == $past(fsel0);
   endproperty
   a_fifo: assert property (p_fifo) else $error("accepted into wrong fifo");

   property p_locked;
      @(posedge clk_i) disable iff (rst_i)
      en_vec[0] && wr_en && adr_w == ADDR_FILTER_CONTROL_SIX
      |=> fsel0 == $past(fsel0) && msel0 == $past(msel0);
   endproperty
   a_locked: assert property (p_locked) else $error("enabled filter reconfigured");

   property p_reset;
      @(posedge clk_i)
      rst_i |=> filter_q == 32'h0000_0000;
   endproperty
   a_reset: assert property (p_reset) else $error("filter control not zero after reset");

   property p_evt_read;
      @(posedge clk_i) disable iff (rst_i)
      rd_take && !wb_req_i.we && is_event_addr(wb_req_i.adr) |=> wb_dat_o[7:4] == 4'h0;
   endproperty
   a_evt_read: assert property (p_evt_read) else $error("reserved event bits read set");

   property p_irq_set;
      @(posedge clk_i) disable iff (rst_i)
      irq_set != 32'h0000_0000 |=> (irq_status_q & $past(irq_set)) == $past(irq_set);
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("overflow event lost");

endmodule

// [verification/can_far_model.sv]
`timescale 1ns/1ns
// ******************************
// Far side: FIFO levels, overflow events, candidates
// ******************************
module can_far_model (
   // Clock
   input wire logic clk_i,
   // Toward the block
   output can_filter_pkg::cand_t cand_o,
   output can_filter_pkg::fifo_in_t [can_filter_pkg::NUM_FIFOS-1:0] fifo_o
);
   import can_filter_pkg::*;

   initial
   begin
      cand_o = '0;
      fifo_o = '0;
   end

   // Occupancy of FIFO n
   task automatic set_level(input int n, input logic [5:0] lvl);
      @(posedge clk_i);
      fifo_o[n].level <= lvl;
      @(posedge clk_i);
   endtask

   // One-cycle overflow pulse on FIFO n
   task automatic overflow(input int n);
      @(posedge clk_i);
      fifo_o[n].overflow_event <= 1'b1;
      @(posedge clk_i);
      fifo_o[n].overflow_event <= 1'b0;
   endtask

   // One-cycle candidate with hit matrix
   task automatic candidate(input logic [15:0] hit);
      @(posedge clk_i);
      cand_o <= {1'b1, hit};
      @(posedge clk_i);
      cand_o <= '0;
   endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
   import can_filter_pkg::*;

   // ******************************
   // Signals and instances
   // ******************************
   logic clk_i;
   logic rst_i;
   wb_req_t wb_req;
   logic [31:0] wb_dat;
   logic wb_ack;
   cand_t cand;
   accept_t accept;
   filter_cfg_t [NUM_FILTERS-1:0] filter_cfg;
   fifo_in_t [NUM_FIFOS-1:0] fifo;
   logic [31:0] fifo_dir;
   logic irq;
   int n_fail = 0;
   int cmp_count = 0;
   logic [5:0] levels [7] = '{6'h00, 6'h01, 6'h0F, 6'h10, 6'h11, 6'h1F, 6'h20};

   can_filter_fifo_status i_can_filter_fifo_status (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_req_i(wb_req),
      .wb_dat_o(wb_dat),
      .wb_ack_o(wb_ack),
      .cand_i(cand),
      .accept_o(accept),
      .filter_cfg_o(filter_cfg),
      .fifo_i(fifo),
      .fifo_direction_tx_o(fifo_dir),
      .irq_o(irq)
   );

   can_far_model i_can_far_model (
      .clk_i(clk_i),
      .cand_o(cand),
      .fifo_o(fifo)
   );

   // ******************************
   // Shared tasks
   // ******************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic wb_xfer(input logic we, input logic [9:0] adr, input logic [31:0] dat,
                          input logic [3:0] sel, output logic [31:0] rd);
      @(posedge clk_i);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
      @(posedge clk_i);
      while (wb_ack !== 1'b1)
      begin
         @(posedge clk_i);
      end
      rd = wb_dat;
      wb_req <= '0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [9:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      logic [31:0] rd;
      wb_xfer(1'b1, adr, dat, sel, rd);
   endtask

   task automatic rd_chk(input logic [9:0] adr, input logic [31:0] exp, input string what);
      logic [31:0] rd;
      wb_xfer(1'b0, adr, 32'h0000_0000, 4'hF, rd);
      check(what, exp, rd);
   endtask

   function automatic logic [9:0] ev(input int n);
      return ADDR_FIFO_EVENT_BASE + 10'(4 * n);
   endfunction

   function automatic logic [31:0] ev_exp(input logic tx, input logic [5:0] lvl,
                                          input logic ovf);
      logic [31:0] e;
      e = 32'h0000_0000;
      if (tx)
      begin
         e[9] = (lvl <= 6'h10);
         e[8] = (lvl == 6'h00);
      end
      else
      begin
         e[3] = ovf;
         e[2] = (lvl == 6'h20);
         e[1] = (lvl >= 6'h10);
         e[0] = (lvl != 6'h00);
      end
      return e;
   endfunction

   // ******************************
   // Scenarios
   // ******************************
   task automatic test_reset;
      rd_chk(ADDR_FILTER_CONTROL_SIX, 32'h0000_0000, "filter control");
      rd_chk(ADDR_FIFO_DIRECTION, 32'h0000_0000, "direction");
      rd_chk(ADDR_IRQ_STATUS, 32'h0000_0000, "irq status");
      rd_chk(ADDR_IRQ_ENABLE, 32'h0000_0000, "irq enable");
      rd_chk(ev(0), 32'h0000_0000, "event 0");
      wr(10'h080, 32'hFFFF_FFFF, 4'hF);
      rd_chk(10'h080, 32'h0000_0000, "unmapped");
      check("irq", 32'(1'b0), 32'(irq));
      $display("test_reset done");
   endtask

   task automatic test_filters;
      wr(ADDR_FILTER_CONTROL_SIX, 32'h7F5A_3D61, 4'hF);
      rd_chk(ADDR_FILTER_CONTROL_SIX, 32'h7F5A_3D61, "filter control");
      check("mask 24", 32'(2'b11), 32'(filter_cfg[0].mask_select));
      check("fifo 27", 32'(5'h1F), 32'(filter_cfg[3].fifo_select));
      i_can_far_model.candidate(16'hFFFF);
      @(negedge clk_i);
      check("accept disabled", 32'(1'b0), 32'(accept.valid));
      wr(ADDR_FILTER_CONTROL_SIX, 32'hFFDA_BDE1, 4'hF);
      rd_chk(ADDR_FILTER_CONTROL_SIX, 32'hFFDA_BDE1, "enable all");
      wr(ADDR_FILTER_CONTROL_SIX, 32'h8080_8080, 4'hF);
      rd_chk(ADDR_FILTER_CONTROL_SIX, 32'hFFDA_BDE1, "locked selects");
      wr(ADDR_FILTER_CONTROL_SIX, 32'h0000_0000, 4'h1);
      rd_chk(ADDR_FILTER_CONTROL_SIX, 32'hFFDA_BD61, "disable 24");
      $display("test_filters done");
   endtask

   task automatic test_accept;
      logic [15:0] hits [7] = '{16'h0008, 16'h0020, 16'h00D0, 16'h0400, 16'h8000,
                                16'h8420, 16'h8421};
      logic [7:0] exp [7] = '{8'h00, 8'hBD, 8'h00, 8'hDA, 8'hFF, 8'hBD, 8'h85};
      for (int i = 0; i < 7; i++)
      begin
         if (i == 6)
         begin
            wr(ADDR_FILTER_CONTROL_SIX, 32'h0000_0085, 4'h1);
         end
         i_can_far_model.candidate(hits[i]);
         @(negedge clk_i);
         check("accept valid", 32'(exp[i][7]), 32'(accept.valid));
         if (exp[i][7])
         begin
            check("accept target", 32'(exp[i][6:0]), 32'({accept.filter, accept.fifo}));
         end
      end
      wr(ADDR_FILTER_CONTROL_SIX, 32'h0000_0085, 4'hE);
      i_can_far_model.candidate(16'hFFFE);
      @(negedge clk_i);
      check("accept only 24", 32'(1'b0), 32'(accept.valid));
      $display("test_accept done");
   endtask

   task automatic test_rx_flags;
      for (int i = 0; i < 7; i++)
      begin
         i_can_far_model.set_level(5, levels[i]);
         rd_chk(ev(5), ev_exp(1'b0, levels[i], 1'b0), "rx flags");
      end
      wr(ev(5), 32'hFFFF_FFFF, 4'hF);
      rd_chk(ev(5), ev_exp(1'b0, 6'h20, 1'b0), "rx after write");
      $display("test_rx_flags done");
   endtask

   task automatic test_tx_flags;
      wr(ADDR_FIFO_DIRECTION, 32'h0000_0200, 4'hF);
      check("direction out", 32'h0000_0200, fifo_dir);
      for (int i = 0; i < 7; i++)
      begin
         i_can_far_model.set_level(9, levels[i]);
         rd_chk(ev(9), ev_exp(1'b1, levels[i], 1'b0), "tx flags");
      end
      i_can_far_model.overflow(9);
      rd_chk(ev(9), ev_exp(1'b1, 6'h20, 1'b0), "tx overflow");
      rd_chk(ADDR_IRQ_STATUS, 32'h0000_0000, "tx status");
      $display("test_tx_flags done");
   endtask

   task automatic test_overflow;
      wr(ADDR_IRQ_ENABLE, 32'h0000_0080, 4'hF);
      i_can_far_model.set_level(7, 6'h03);
      i_can_far_model.overflow(7);
      @(posedge clk_i);
      check("irq set", 32'(1'b1), 32'(irq));
      rd_chk(ev(7), ev_exp(1'b0, 6'h03, 1'b1), "overflow");
      rd_chk(ADDR_IRQ_STATUS, 32'h0000_0080, "status");
      repeat (20) @(posedge clk_i);
      wr(ev(7), 32'h0000_0000, 4'h1);
      rd_chk(ev(7), ev_exp(1'b0, 6'h03, 1'b1), "overflow held");
      wr(ev(7), 32'h0000_0008, 4'h1);
      rd_chk(ev(7), ev_exp(1'b0, 6'h03, 1'b0), "overflow cleared");
      wr(ADDR_IRQ_CLEAR, 32'h0000_0080, 4'hF);
      rd_chk(ADDR_IRQ_STATUS, 32'h0000_0000, "status cleared");
      check("irq clear", 32'(1'b0), 32'(irq));
      i_can_far_model.overflow(7);
      wr(ADDR_IRQ_ENABLE, 32'h0000_0000, 4'hF);
      check("irq masked", 32'(1'b0), 32'(irq));
      wr(ADDR_IRQ_ENABLE, 32'h0000_0080, 4'hF);
      check("irq unmasked", 32'(1'b1), 32'(irq));
      $display("test_overflow done");
   endtask

   // ******************************
   // Run control
   // ******************************
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial
   begin
      rst_i = 1'b1;
      wb_req = '0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      test_reset();
      test_filters();
      test_accept();
      test_rx_flags();
      test_tx_flags();
      test_overflow();
      report_and_stop();
   end

   initial
   begin
      #200000;
      n_fail++;
      $display("unexpected run length: expected end, seen none");
      report_and_stop();
   end
endmodule
